/* File: hdl/clsr_map.vh */
`ifndef CLSR_MAP_VH
`define CLSR_MAP_VH

// ==========================================================
// Array geometry
`define CLSR_ELEMENTS 8'h80
`define CLSR_UPPER_OFS 9'h080
`define CLSR_SAMPLE_W 12
`define CLSR_CHAN_W 9
`define CLSR_WORD_W 21

// ==========================================================
// Scan timing, in sensor clocks
`define CLSR_TRIG_FIRST 10'h013
`define CLSR_CH_PITCH 10'h004
`define CLSR_EOS_LEAD 10'h002
`define CLSR_EOS_LEN 3'h4
`define CLSR_FOLLOW_FIRST 10'h012

// ==========================================================
// Integration timing, in sensor clocks
`define CLSR_INT_START 6'h1e
`define CLSR_INT_END 6'h08
`define CLSR_RCNT_MAX 6'h3f

// ==========================================================
// Reset values
`define CLSR_RST_FCNT 10'h000
// Idle pin levels: clock low, reset low, start high, high gain, lower half
`define CLSR_RST_PINS 5'h0c

`endif

/* File: hdl/clsr_readout.v */
// Summary of operation
// - Lower half chip gives channels 1-128, upper half chip 129-256.
// - Dual serial: lower first-in-chain, upper follower, 256 channels in order.
// - Dual parallel: both first-in-chain, each gives 128 channels at once.
// - Gain pin high picks 0.125 pF high gain, low picks 0.25 pF.
// - Sequence starts at first clock fall after reset low; that is clock 1.
// - Channel 1 at 18.5-20.5, trigger rises 19.5, both repeat every 4 clocks.
// - Integration from 30 clocks after reset rise to 8 after fall.
`timescale 1ns/1ns
`include "clsr_map.vh"

module clsr_readout (
    // Clock and reset
    input wire mclk,
    input wire srst,
    // Pins from the controller and the chain
    input wire sclk_pin,
    input wire sreset_pin,
    input wire chain_start_in_n,
    input wire master_sel,
    input wire gain_sel,
    // Static strap: 1 = upper half chip of a dual module
    input wire upper_half_chip,
    // Pixel sample for the channel being read
    input wire [`CLSR_SAMPLE_W-1:0] pixel_level,
    // Pin outputs
    output reg trig_out,
    output reg scan_done_out_n,
    output reg integrating,
    output reg feedback_setting,
    output reg overrun,
    // Video word stream
    output wire video_valid,
    output wire [`CLSR_WORD_W-1:0] video_word,
    input wire video_ready
);

// ==========================================================
// States
localparam ST_IDLE = 4'b0001;
localparam ST_ARM = 4'b0010;
localparam ST_SCAN = 4'b0100;
localparam ST_EOS = 4'b1000;

// ==========================================================
// Pin synchronisers: bit 0 clock, 1 reset, 2 start, 3 gain, 4 half
reg [4:0] pin_s1;
reg [4:0] pin_s2;
reg [4:0] pin_s3;
reg [4:0] pin_q;
reg sclk_last;
reg rst_last;
reg start_last;
wire sclk_rise;
wire sclk_fall;
wire rst_rise;
wire rst_fall;
wire start_fall;

// A change counts only once the second and third stages agree
function [4:0] settle;
    input [4:0] cur;
    input [4:0] b;
    input [4:0] c;
    begin
        // Agreeing stages give the new level, disagreeing ones keep the old
        settle = (b & c) | (cur & (b ^ c));
    end
endfunction

always @(posedge mclk) begin
    if (srst) begin
        pin_s1 <= `CLSR_RST_PINS;
        pin_s2 <= `CLSR_RST_PINS;
        pin_s3 <= `CLSR_RST_PINS;
        pin_q <= `CLSR_RST_PINS;
        // Match the idle pin levels, so no false edge follows reset
        sclk_last <= 1'b0;
        rst_last <= 1'b0;
        start_last <= 1'b1;
    end else begin
        pin_s1 <= {upper_half_chip, gain_sel, chain_start_in_n, sreset_pin, sclk_pin};
        pin_s2 <= pin_s1;
        pin_s3 <= pin_s2;
        pin_q <= settle(pin_q, pin_s2, pin_s3);
        sclk_last <= pin_q[0];
        rst_last <= pin_q[1];
        start_last <= pin_q[2];
    end
end

assign sclk_rise = pin_q[0] & ~sclk_last;
assign sclk_fall = ~pin_q[0] & sclk_last;
assign rst_rise = pin_q[1] & ~rst_last;
assign rst_fall = ~pin_q[1] & rst_last;
assign start_fall = ~pin_q[2] & start_last;

// ==========================================================
// Gain selection
always @(posedge mclk) begin
    if (srst) begin
        feedback_setting <= 1'b1;
    end else begin
        feedback_setting <= pin_q[3];
    end
end

// ==========================================================
// Integration window, counted on sensor clock rises
reg [5:0] rcnt;
wire [5:0] next_rcnt;

assign next_rcnt = (rcnt == `CLSR_RCNT_MAX) ? rcnt : rcnt + 6'h01;

always @(posedge mclk) begin
    if (srst) begin
        rcnt <= `CLSR_RCNT_MAX;
        integrating <= 1'b0;
    end else if (rst_rise || rst_fall) begin
        rcnt <= 6'h00;
    end else if (sclk_rise) begin
        rcnt <= next_rcnt;
        if (pin_q[1] && next_rcnt == `CLSR_INT_START) begin
            integrating <= 1'b1;
        end else if (!pin_q[1] && next_rcnt == `CLSR_INT_END) begin
            integrating <= 1'b0;
        end
    end
end

// ==========================================================
// Scan sequencer
reg [3:0] state;
reg [9:0] fcnt;
reg [9:0] trig_at;
reg [7:0] ch_cnt;
reg [2:0] eos_cnt;
reg push_valid;
reg [`CLSR_WORD_W-1:0] push_word;
wire push_ready;
wire [`CLSR_CHAN_W-1:0] chan_num;
wire [`CLSR_SAMPLE_W-1:0] scaled;
wire [9:0] next_fcnt;
wire scan_trig;

// Channel numbering carries the half offset of a dual module
assign chan_num = {1'b0, ch_cnt} + 9'h001 + (pin_q[4] ? `CLSR_UPPER_OFS : 9'h000);
// Doubled feedback capacitance halves the charge gain
assign scaled = feedback_setting ? pixel_level : {1'b0, pixel_level[`CLSR_SAMPLE_W-1:1]};
assign next_fcnt = fcnt + 10'h001;
assign scan_trig = (fcnt == trig_at) && (ch_cnt != `CLSR_ELEMENTS);

always @(posedge mclk) begin
    if (srst) begin
        state <= ST_IDLE;
        fcnt <= `CLSR_RST_FCNT;
        trig_at <= `CLSR_TRIG_FIRST;
        ch_cnt <= 8'h00;
        eos_cnt <= 3'h0;
        trig_out <= 1'b0;
        scan_done_out_n <= 1'b1;
        push_valid <= 1'b0;
        push_word <= {`CLSR_WORD_W{1'b0}};
        overrun <= 1'b0;
    end else begin
        push_valid <= 1'b0;
        // A fresh start always restarts; reset rise mid-video is the controller's fault
        if (master_sel && rst_fall) begin
            state <= ST_ARM;
            fcnt <= `CLSR_RST_FCNT;
            scan_done_out_n <= 1'b1;
            trig_out <= 1'b0;
        end else if (!master_sel && start_fall) begin
            // Follower picks up right where the previous chip stopped
            state <= ST_ARM;
            fcnt <= `CLSR_FOLLOW_FIRST - 10'h001;
            scan_done_out_n <= 1'b1;
            trig_out <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    trig_out <= 1'b0;
                end
                ST_ARM: begin
                    if (sclk_fall) begin
                        state <= ST_SCAN;
                        fcnt <= next_fcnt;
                        trig_at <= `CLSR_TRIG_FIRST;
                        ch_cnt <= 8'h00;
                        overrun <= 1'b0;
                    end
                end
                ST_SCAN: begin
                    if (sclk_rise) begin
                        trig_out <= scan_trig;
                        if (scan_trig) begin
                            push_valid <= 1'b1;
                            push_word <= {chan_num, scaled};
                            ch_cnt <= ch_cnt + 8'h01;
                            trig_at <= trig_at + `CLSR_CH_PITCH;
                        end
                    end else if (sclk_fall) begin
                        fcnt <= next_fcnt;
                        if (ch_cnt == `CLSR_ELEMENTS &&
                            next_fcnt == trig_at - `CLSR_EOS_LEAD) begin
                            state <= ST_EOS;
                            scan_done_out_n <= 1'b0;
                            eos_cnt <= 3'h0;
                        end
                    end
                end
                ST_EOS: begin
                    if (sclk_rise) begin
                        trig_out <= 1'b0;
                    end else if (sclk_fall) begin
                        eos_cnt <= eos_cnt + 3'h1;
                        if (eos_cnt == `CLSR_EOS_LEN - 3'h1) begin
                            scan_done_out_n <= 1'b1;
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
        // Word refused by a full buffer is flagged until the next scan; set beats clear
        if (push_valid && !push_ready) begin
            overrun <= 1'b1;
        end
    end
end

// ==========================================================
// Stall buffer between the sequencer and the reader
clsr_word_buf u_buf (
    .mclk(mclk),
    .srst(srst),
    .in_valid(push_valid),
    .in_data(push_word),
    .in_ready(push_ready),
    .out_valid(video_valid),
    .out_data(video_word),
    .out_ready(video_ready)
);

endmodule

/* File: hdl/clsr_word_buf.v */
`timescale 1ns/1ns
`include "clsr_map.vh"

module clsr_word_buf (
    // Clock and reset
    input wire mclk,
    input wire srst,
    // Filling side
    input wire in_valid,
    input wire [`CLSR_WORD_W-1:0] in_data,
    output reg in_ready,
    // Draining side
    output reg out_valid,
    output reg [`CLSR_WORD_W-1:0] out_data,
    input wire out_ready
);

reg [`CLSR_WORD_W-1:0] tail_data;
wire pop;
wire push;

// ==========================================================
// Two entries: head feeds the port, tail catches a stalled word
assign pop = out_valid & out_ready;
assign push = in_valid & in_ready;

always @(posedge mclk) begin
    if (srst) begin
        out_valid <= 1'b0;
        in_ready <= 1'b1;
        out_data <= {`CLSR_WORD_W{1'b0}};
        tail_data <= {`CLSR_WORD_W{1'b0}};
    end else if (pop) begin
        if (!in_ready) begin
            out_data <= tail_data;
            in_ready <= 1'b1;
        end else if (push) begin
            out_data <= in_data;
        end else begin
            out_valid <= 1'b0;
        end
    end else if (push) begin
        if (!out_valid) begin
            out_data <= in_data;
            out_valid <= 1'b1;
        end else begin
            tail_data <= in_data;
            in_ready <= 1'b0;
        end
    end
end

endmodule

/* File: verification/clsr_ctrl_model.sv */
`timescale 1ns/1ns
// ==========================================================
// Controller: sensor clock of 12 mclk, one reset pulse a line
module clsr_ctrl_model #(parameter HIGH = 40, parameter LINE = 620) (
    // Clock and reset
    input wire mclk,
    input wire srst,
    // Pins shared by all chips
    output reg sclk_pin,
    output reg sreset_pin
);
    integer div, cnt;
    always @(posedge mclk) begin
        if (srst) begin
            div <= 0;
            cnt <= 0;
            sclk_pin <= 1'b0;
            sreset_pin <= 1'b0;
        end else begin
            div <= (div == 5) ? 0 : div + 1;
            if (div == 5) sclk_pin <= ~sclk_pin;
            if (div == 5 && !sclk_pin) begin
                // Moves with a clock rise; low stretch outlasts any scan
                sreset_pin <= (cnt < HIGH);
                cnt <= (cnt == LINE - 1) ? 0 : cnt + 1;
            end
        end
    end
endmodule

/* File: verification/clsr_readout_assertions.sv */
`timescale 1ns/1ns
`include "clsr_map.vh"
module clsr_readout_chk (
    // Clock and reset
    input wire mclk,
    input wire srst,
    // Pins
    input wire sreset_pin,
    input wire gain_sel,
    input wire upper_half_chip,
    input wire trig_out,
    input wire scan_done_out_n,
    input wire integrating,
    input wire feedback_setting,
    input wire overrun,
    // Stream
    input wire video_valid,
    input wire [`CLSR_WORD_W-1:0] video_word,
    input wire video_ready
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // ==========================================================
    // Pin timing; windows allow for the pin synchroniser
    property p_tw; $rose(trig_out) |=> trig_out [*8] ##[1:6] !trig_out; endproperty
    a_tw: assert property (p_tw) else $error("trigger width");
    property p_dn; $fell(scan_done_out_n) |=> !scan_done_out_n [*8]; endproperty
    a_dn: assert property (p_dn) else $error("scan done short");
    property p_gs; $changed(gain_sel) ##1 $stable(gain_sel) [*8] |-> feedback_setting == gain_sel;
    endproperty
    a_gs: assert property (p_gs) else $error("gain setting");
    property p_is; $rose(integrating) |-> sreset_pin; endproperty
    a_is: assert property (p_is) else $error("integration start");
    property p_ie; $fell(integrating) |-> !sreset_pin; endproperty
    a_ie: assert property (p_ie) else $error("integration end");
    property p_hf; video_valid |-> (video_word[20:12] > 9'h080) == upper_half_chip; endproperty
    a_hf: assert property (p_hf) else $error("channel half");
    // A stalled word must not change, or the reader loses it
    property p_hd; video_valid && !video_ready |=> video_valid && $stable(video_word); endproperty
    a_hd: assert property (p_hd) else $error("word not held");
    property p_ov; $rose(overrun) |-> $past(video_valid) && !$past(video_ready); endproperty
    a_ov: assert property (p_ov) else $error("overrun cause");
    c_tr: cover property ($rose(trig_out));
    c_dn: cover property ($fell(scan_done_out_n));
    c_ov: cover property ($rose(overrun));
endmodule

/* File: verification/tb.sv */
`timescale 1ns/1ns
`include "clsr_map.vh"
module tb;
    reg mclk = 1'b0, srst = 1'b1, chain_start_in_n = 1'b1, master_sel = 1'b1;
    reg gain_sel = 1'b1, upper_half_chip = 1'b0, video_ready = 1'b1;
    reg [`CLSR_SAMPLE_W-1:0] pixel_level = 12'h5a6;
    reg [`CLSR_WORD_W-1:0] got [0:127];
    integer n_got = 0, n_trig = 0, num_errors = 0, num_checks = 0, k, span;
    wire sclk_pin, sreset_pin, trig_out, scan_done_out_n, integrating, feedback_setting;
    wire overrun, video_valid;
    wire [`CLSR_WORD_W-1:0] video_word;
    // ==========================================================
    // Device, controller and monitors
    initial forever #25 mclk = ~mclk;
    clsr_ctrl_model u_clsr_ctrl_model (
        .mclk(mclk),
        .srst(srst),
        .sclk_pin(sclk_pin),
        .sreset_pin(sreset_pin)
    );
    clsr_readout u_clsr_readout (
        .mclk(mclk),
        .srst(srst),
        .sclk_pin(sclk_pin),
        .sreset_pin(sreset_pin),
        .chain_start_in_n(chain_start_in_n),
        .master_sel(master_sel),
        .gain_sel(gain_sel),
        .upper_half_chip(upper_half_chip),
        .pixel_level(pixel_level),
        .trig_out(trig_out),
        .scan_done_out_n(scan_done_out_n),
        .integrating(integrating),
        .feedback_setting(feedback_setting),
        .overrun(overrun),
        .video_valid(video_valid),
        .video_word(video_word),
        .video_ready(video_ready)
    );
    always @(posedge mclk) begin
        if (video_valid === 1'b1 && video_ready === 1'b1 && n_got < 128) begin
            got[n_got] <= video_word;
            n_got <= n_got + 1;
        end
    end
    always @(posedge trig_out) n_trig = n_trig + 1;
    // ==========================================================
    // Tasks
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Straps move at once, before the reset rise that starts the next line
    task start_line(input ms, input up, input gs);
        master_sel = ms;
        upper_half_chip = up;
        gain_sel = gs;
        @(posedge sreset_pin);
        @(negedge mclk);
        n_got = 0;
        n_trig = 0;
    endtask
    task wait_words(input integer n);
        for (k = 0; k < 9000 && n_got < n; k = k + 1) @(negedge mclk);
        check(n_got >= n, 1'b1);
    endtask
    task check_scan(input [8:0] first, input [11:0] pix);
        wait_words(128);
        check(n_trig, 32'h80);
        for (k = 0; k < 128; k = k + 1) check(got[k], {first + k[8:0], pix});
    endtask
    task test_master;
        start_line(1'b1, 1'b0, 1'b1);
        span = 0;
        while (integrating !== 1'b1 && span < 1000) begin
            @(negedge mclk);
            span = span + 1;
        end
        // 30 sensor clocks of 12 mclk, plus a few for the pin synchroniser
        check(span >= 32'h168 && span <= 32'h16e, 1'b1);
        span = 0;
        while (integrating === 1'b1 && span < 1000) begin
            @(negedge mclk);
            span = span + 1;
        end
        // Reset high 40 clocks less 22, 12 mclk each
        check(span, 32'h0d8);
        check_scan(9'h001, 12'h5a6);
        check(feedback_setting, 1'b1);
        span = 0;
        while (scan_done_out_n !== 1'b0 && span < 1000) begin
            @(negedge mclk);
            span = span + 1;
        end
        span = 0;
        while (scan_done_out_n === 1'b0 && span < 1000) begin
            @(negedge mclk);
            span = span + 1;
        end
        // Scan done pulse lasts 4 sensor clocks of 12 mclk
        check(span, 32'h030);
        $display("master done");
    endtask
    task test_follower;
        start_line(1'b0, 1'b1, 1'b0);
        @(negedge sreset_pin);
        repeat (360) @(negedge mclk);
        check(n_got, 32'h0);
        chain_start_in_n = 1'b0;
        repeat (48) @(negedge mclk);
        chain_start_in_n = 1'b1;
        check_scan(9'h081, 12'h2d3);
        check(feedback_setting, 1'b0);
        $display("follower done");
    endtask
    task test_stall;
        start_line(1'b1, 1'b1, 1'b1);
        video_ready = 1'b0;
        @(negedge sreset_pin);
        repeat (1200) @(negedge mclk);
        check({overrun, video_valid}, 2'h3);
        video_ready = 1'b1;
        wait_words(2);
        check(got[0], {9'h081, 12'h5a6});
        check(got[1], {9'h082, 12'h5a6});
        $display("stall done");
    endtask
    task finish_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge mclk);
        srst = 1'b0;
        test_master;
        test_follower;
        test_stall;
        finish_test;
    end
    // About 2.4 times the expected run
    initial begin
        repeat (40000) @(posedge mclk);
        num_errors = num_errors + 1;
        $display("Error at %0t: watchdog expired", $time);
        finish_test;
    end
endmodule
bind clsr_readout clsr_readout_chk u_clsr_readout_chk (
    .mclk(mclk),
    .srst(srst),
    .sreset_pin(sreset_pin),
    .gain_sel(gain_sel),
    .upper_half_chip(upper_half_chip),
    .trig_out(trig_out),
    .scan_done_out_n(scan_done_out_n),
    .integrating(integrating),
    .feedback_setting(feedback_setting),
    .overrun(overrun),
    .video_valid(video_valid),
    .video_word(video_word),
    .video_ready(video_ready)
);
